// ==== rtl/ssr_pkg.sv ====
// shared constants and pin bundle for the serial shift-and-store register
package ssr_pkg;

  // number of shift stages and storage latches
  localparam int SSR_STAGES = 8;
  // synchroniser depth for pin inputs
  localparam int SSR_SYNC_DEPTH = 2;
  // reset value of shift stages, storage latches and cascade outputs
  localparam logic [SSR_STAGES-1:0] SSR_DATA_RST = 8'h00;
  localparam logic SSR_BIT_RST = 1'h0;
  // resting level of the synchronised pins after reset
  localparam logic [3:0] SSR_PINS_RST = 4'h0;

  // control and data pins from the outside controller
  typedef struct packed {
    logic shift_clock;
    logic serial_in;
    logic latch_gate;
    logic drive_enable;
  } ssr_pins_t;

endpackage

// ==== rtl/ssr_sync.sv ====
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
`default_nettype none

module ssr_sync
  import ssr_pkg::*;
#(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // first stage is read only by the second stage
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule

`default_nettype wire

// ==== rtl/ssr_top.sv ====
// serial shift-and-store register with three-state parallel outputs
// What this block does
// - eight shift stages, each with latch and output
// - shift clock rise shifts serial_in in
// - latches follow stages while latch_gate high
// - drive_enable high shows latches, latches undisturbed
// - par_oe_n high, releasing the bus, while drive_enable low
// - rise moves stage seven to eight, fast_cascade_out
// - slow_cascade_out takes last bit on falling edge
// - each cascade output updates on one edge only
`timescale 1ns/10ps
`default_nettype none

module ssr_top
  import ssr_pkg::*;
#(
  parameter int STAGES = SSR_STAGES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire ssr_pins_t pins_in,
  output logic [STAGES-1:0] par_out,
  output logic par_oe_n,
  output logic fast_cascade_out,
  output logic slow_cascade_out
);

  ssr_pins_t pins_s;
  logic [3:0] pins_s_bits;
  logic clk_prev_ff;
  logic clk_rise;
  logic clk_fall;
  logic [STAGES-1:0] stage_ff;
  logic [STAGES-1:0] nxt_stage;
  logic [STAGES-1:0] latch_ff;
  logic slow_ff;

  // bring all controller pins into the system clock domain
  ssr_sync #(
    .WIDTH(4),
    .RST_VAL(SSR_PINS_RST)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .async_in(pins_in),
    .sync_out(pins_s_bits)
  );

  assign pins_s = ssr_pins_t'(pins_s_bits);

  // remember previous synchronised shift clock level for edge detection
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clk_prev_ff <= SSR_BIT_RST;
    end else begin
      clk_prev_ff <= pins_s.shift_clock;
    end
  end

  // one-cycle pulses on each edge of the shift clock
  assign clk_rise = pins_s.shift_clock & ~clk_prev_ff;
  assign clk_fall = ~pins_s.shift_clock & clk_prev_ff;

  // next shift value: serial_in enters stage one, others move along
  always_comb begin
    nxt_stage = stage_ff;
    if (clk_rise) begin
      nxt_stage = {stage_ff[STAGES-2:0], pins_s.serial_in};
    end
  end

  // shift stages; cleared only so simulation is defined, not a device reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stage_ff <= SSR_DATA_RST;
    end else begin
      stage_ff <= nxt_stage;
    end
  end

  // storage latches are transparent to the next stage value while gated
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      latch_ff <= SSR_DATA_RST;
    end else if (pins_s.latch_gate) begin
      latch_ff <= nxt_stage;
    end
  end

  // parallel outputs come straight from the latches; enable does not touch them
  assign par_out = latch_ff;
  // active-low drive enable: low while the outputs drive the bus
  assign par_oe_n = ~pins_s.drive_enable;

  // last stage doubles as the rising-edge cascade output
  assign fast_cascade_out = stage_ff[STAGES-1];

  // slow cascade copy taken on the falling edge only
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      slow_ff <= SSR_BIT_RST;
    end else if (clk_fall) begin
      slow_ff <= stage_ff[STAGES-1];
    end
  end

  // cascade outputs run regardless of drive_enable
  assign slow_cascade_out = slow_ff;

  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // a clean rising edge on the pin held for three samples
  sequence s_pin_rise;
    !pins_in.shift_clock ##1 pins_in.shift_clock [*3];
  endsequence

  // a detected rising edge followed by one idle cycle
  sequence s_rise_then_idle;
    clk_rise ##1 !clk_rise;
  endsequence

  property p_shift_in;
    clk_rise |=> stage_ff == {$past(stage_ff[STAGES-2:0]), $past(pins_s.serial_in)};
  endproperty
  a_shift_in: assert property (p_shift_in)
    else $error("shift stages did not shift on clock rise");

  property p_stage_hold;
    !clk_rise |=> $stable(stage_ff);
  endproperty
  a_stage_hold: assert property (p_stage_hold)
    else $error("shift stages changed without clock rise");

  property p_pin_to_shift;
    s_pin_rise |-> ##[0:3] clk_rise;
  endproperty
  a_pin_to_shift: assert property (p_pin_to_shift)
    else $error("pin clock rise not seen within three cycles");

  property p_latch_follow;
    pins_s.latch_gate |=> latch_ff == stage_ff;
  endproperty
  a_latch_follow: assert property (p_latch_follow)
    else $error("latches did not follow stages while gated");

  property p_latch_hold;
    !pins_s.latch_gate |=> $stable(latch_ff);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latches changed while gate low");

  // enable pin high for three samples has passed the synchroniser
  property p_drive_shows_latch;
    pins_in.drive_enable [*3] |-> !par_oe_n && par_out == latch_ff;
  endproperty
  a_drive_shows_latch: assert property (p_drive_shows_latch)
    else $error("enabled outputs do not show latch contents");

  property p_enable_no_disturb;
    (!pins_s.latch_gate && $changed(pins_s.drive_enable)) |=> $stable(latch_ff);
  endproperty
  a_enable_no_disturb: assert property (p_enable_no_disturb)
    else $error("drive enable disturbed latches");

  // enable pin low for three samples must have released the bus
  property p_float;
    (!pins_in.drive_enable) [*3] |-> par_oe_n;
  endproperty
  a_float: assert property (p_float)
    else $error("outputs driven while enable low");

  property p_fast_cascade;
    s_rise_then_idle |-> fast_cascade_out == $past(stage_ff[STAGES-2]);
  endproperty
  a_fast_cascade: assert property (p_fast_cascade)
    else $error("fast cascade not stage seven after rise");

  property p_slow_cascade;
    clk_fall |=> slow_cascade_out == $past(fast_cascade_out);
  endproperty
  a_slow_cascade: assert property (p_slow_cascade)
    else $error("slow cascade did not copy last stage on fall");

  property p_fast_on_rise_only;
    clk_fall |=> $stable(fast_cascade_out);
  endproperty
  a_fast_on_rise_only: assert property (p_fast_on_rise_only)
    else $error("fast cascade changed on falling edge");

  property p_slow_on_fall_only;
    !clk_fall |=> $stable(slow_cascade_out);
  endproperty
  a_slow_on_fall_only: assert property (p_slow_on_fall_only)
    else $error("slow cascade changed without falling edge");

endmodule

`default_nettype wire

// ==== testbench/ssr_ctrl_model.sv ====
// controller model driving the data and strobe pins
`timescale 1ns/10ps
`default_nettype none

module ssr_ctrl_model
  import ssr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic fast_cascade_out,
  input wire logic slow_cascade_out,
  output var ssr_pins_t pins
);
  initial pins = SSR_PINS_RST;

  // each level stands well past the two-flop synchroniser delay
  task automatic hold();
    repeat (6) @(posedge clk_sys);
  endtask

  // data set up ahead of the rise and held until the next bit
  task automatic rise(input logic d);
    @(posedge clk_sys);
    pins.serial_in <= d;
    hold();
    pins.shift_clock <= 1'h1;
    hold();
  endtask

  // falling half of the shift clock
  task automatic fall();
    pins.shift_clock <= 1'h0;
    hold();
  endtask

  // strobe and enable levels
  task automatic set_ctl(input logic gate, input logic oe);
    @(posedge clk_sys);
    pins.latch_gate <= gate;
    pins.drive_enable <= oe;
    hold();
  endtask

  // bit a chained register takes at the next rise; slow clock edges use the slow copy
  task automatic chain_pick(input logic slow_edges, output logic d);
    d = slow_edges ? slow_cascade_out : fast_cascade_out;
  endtask
endmodule

`default_nettype wire

// ==== testbench/test_ssr_top.sv ====
// self-checking bench for the shift-and-store register
`timescale 1ns/10ps
`default_nettype none

module test_ssr_top;
  import ssr_pkg::*;
  logic clk_sys;
  logic rst;
  ssr_pins_t pins_in;
  logic [SSR_STAGES-1:0] par_out;
  logic par_oe_n;
  logic fast_cascade_out;
  logic slow_cascade_out;
  logic [SSR_STAGES-1:0] exp_stage;
  logic exp_slow;
  int fail_count;
  int checks_done;
  int cycles;

  ssr_top u_ssr_top (.clk_sys(clk_sys), .rst(rst), .pins_in(pins_in), .par_out(par_out),
    .par_oe_n(par_oe_n), .fast_cascade_out(fast_cascade_out),
    .slow_cascade_out(slow_cascade_out));
  ssr_ctrl_model u_ssr_ctrl_model (.clk_sys(clk_sys), .fast_cascade_out(fast_cascade_out),
    .slow_cascade_out(slow_cascade_out), .pins(pins_in));

  // clock generation
  initial begin
    clk_sys = 1'h0;
    forever #25 clk_sys = ~clk_sys;
  end

  // hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic cmp_bus(input logic [SSR_STAGES-1:0] got, input logic [SSR_STAGES-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t par_out %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t output bit %b expected %b", $time, got, exp);
    end
  endtask

  // shift a byte msb first, watching both cascade outputs on every edge
  task automatic shift_byte(input logic [SSR_STAGES-1:0] b);
    logic chain_d;
    for (int i = SSR_STAGES - 1; i >= 0; i--) begin
      u_ssr_ctrl_model.chain_pick(i[0], chain_d);
      cmp_bit(chain_d, exp_stage[SSR_STAGES-1]);
      u_ssr_ctrl_model.rise(b[i]);
      exp_stage = {exp_stage[SSR_STAGES-2:0], b[i]};
      cmp_bit(fast_cascade_out, exp_stage[SSR_STAGES-1]);
      cmp_bit(slow_cascade_out, exp_slow);
      u_ssr_ctrl_model.fall();
      exp_slow = exp_stage[SSR_STAGES-1];
      cmp_bit(slow_cascade_out, exp_slow);
      cmp_bit(fast_cascade_out, exp_slow);
    end
  endtask

  task automatic test_load();
    u_ssr_ctrl_model.set_ctl(1'h1, 1'h1);
    cmp_bit(par_oe_n, 1'h0);
    shift_byte(8'ha5);
    cmp_bus(par_out, 8'ha5);
    $display("test_load done");
  endtask

  task automatic test_hold();
    u_ssr_ctrl_model.set_ctl(1'h0, 1'h0);
    shift_byte(8'h3c);
    cmp_bit(par_oe_n, 1'h1);
    u_ssr_ctrl_model.set_ctl(1'h0, 1'h1);
    cmp_bus(par_out, 8'ha5);
    u_ssr_ctrl_model.set_ctl(1'h1, 1'h1);
    cmp_bus(par_out, 8'h3c);
    $display("test_hold done");
  endtask

  task automatic test_float();
    u_ssr_ctrl_model.set_ctl(1'h1, 1'h0);
    cmp_bit(par_oe_n, 1'h1);
    shift_byte(8'h81);
    u_ssr_ctrl_model.set_ctl(1'h1, 1'h1);
    cmp_bit(par_oe_n, 1'h0);
    cmp_bus(par_out, 8'h81);
    $display("test_float done");
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // reset, then the scenarios in turn
  initial begin
    rst = 1'h1;
    fail_count = 0;
    checks_done = 0;
    cycles = 0;
    exp_stage = SSR_DATA_RST;
    exp_slow = SSR_BIT_RST;
    repeat (16) @(posedge clk_sys);
    rst <= 1'h0;
    test_load();
    test_hold();
    test_float();
    summarize();
  end
endmodule

`default_nettype wire
